/* File: logic/fpe_pkg.sv */
// Constants, offsets and modes shared by the feeder protection elements.
package fpe_pkg;

  // ---------------------------------------------------------------
  // Element function modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_OFF = 3'h0,
    FN_TRIP = 3'h1,
    FN_ALARM = 3'h2,
    FN_LATCH = 3'h3,
    FN_CTRL = 3'h4
  } fpe_func_e;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_FD_CFG = 8'h00;
  localparam logic [7:0] A_FD_LVL = 8'h04;
  localparam logic [7:0] A_BF_CFG = 8'h08;
  localparam logic [7:0] A_BF_DLY = 8'h0c;
  localparam logic [7:0] A_RP_CFG = 8'h10;
  localparam logic [7:0] A_RP_DLY = 8'h14;
  localparam logic [7:0] A_NC_CFG = 8'h18;
  localparam logic [7:0] A_NC_LVL = 8'h1c;
  localparam logic [7:0] A_PF_CFG0 = 8'h20;
  localparam logic [7:0] A_PF_DLY0 = 8'h24;
  localparam logic [7:0] A_PF_CFG1 = 8'h28;
  localparam logic [7:0] A_PF_DLY1 = 8'h2c;
  localparam logic [7:0] A_CMD = 8'h30;
  localparam logic [7:0] A_STAT = 8'h34;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Timing: delays count 10 ms ticks, neutral delay counts seconds
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_PERIOD_MS = 10;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned SEC_TICKS = 100;

  // ---------------------------------------------------------------
  // Setting ranges and values after reset
  // ---------------------------------------------------------------
  localparam logic [15:0] FD_RATE_MIN = 16'h0001;
  localparam logic [15:0] FD_RATE_MAX = 16'h0032;
  localparam logic [15:0] FD_RATE_RST = 16'h000a;
  localparam logic [15:0] FD_PU_MIN = 16'h07d0;
  localparam logic [15:0] FD_PU_MAX = 16'h1964;
  localparam logic [15:0] FD_PU_RST = 16'h170c;
  localparam logic [15:0] FD_DLY_MAX = 16'hea60;
  localparam logic [15:0] FD_DLY_RST = 16'h00c8;
  localparam logic [15:0] SUP_MAX = 16'h007d;
  localparam logic [15:0] FD_V_RST = 16'h0046;
  localparam logic [15:0] NC_PU_MIN = 16'h0005;
  localparam logic [15:0] NC_PU_MAX = 16'h07d0;
  localparam logic [15:0] NC_PU_RST = 16'h0064;
  localparam logic [15:0] NC_DLY_MAX = 16'hea60;
  localparam logic [15:0] NC_DLY_RST = 16'h0002;
  localparam logic [15:0] V30 = 16'h001e;
  localparam logic [15:0] BF_I_RST = 16'h0064;
  localparam logic [15:0] BF_DLY_RST = 16'h000a;
  localparam logic [15:0] RP_PU_RST = 16'h0010;
  localparam logic [15:0] RP_DLY_RST = 16'h0064;
  localparam logic [7:0] PF_PU_RST = 8'h50;
  localparam logic [7:0] PF_DR_RST = 8'h5a;
  localparam logic [15:0] PF_DLY_RST = 16'h01f4;

endpackage : fpe_pkg

/* File: logic/fpe_top.sv */
// Feeder protection and monitoring elements with an AXI4-Lite setting port.
//
// Summary of operation
// [RULE1] Decay element modes: off, trip, alarm, latch, control.
// [RULE2] Each element drives chosen aux relays 3-7.
// [RULE3] Decay rate 0.1 to 5.0 Hz/s.
// [RULE4] Decay pickup 20.00 to 65.00 Hz.
// [RULE5] Decay delay 0 to 600.00 s.
// [RULE6] Decay minimum voltage 0 to 1.25 VT.
// [RULE7] Decay minimum current 0 to 1.25 CT.
// [RULE8] Breaker fails if current persists after delays.
// [RULE9] Failure drives relays and forces reclose lockout.
// [RULE10] First failure timer starts on trip.
// [RULE11] Second timer needs trip, first expired, current.
// [RULE12] Reverse power above pickup operates after delay.
// [RULE13] Neutral level element has no trip mode.
// [RULE14] Neutral pickup 0.05 to 20.00 CT.
// [RULE15] Neutral delay 0 to 60000 s.
// [RULE16] One three-phase average power factor feeds both.
// [RULE17] Power factor below pickup operates element.
// [RULE18] Resets after above dropout for delay.
// [RULE19] Needs all voltages over 30%, some current.
// [RULE20] Timers run only with voltage and condition.
// [RULE21] Voltage loss resets both power factor elements.
// [RULE22] Decay blocked below minimum current.
// [RULE23] Decay blocked below minimum voltage.
// [RULE24] Decay timer runs on low frequency, fast fall.
// [RULE25] Latched alarm holds until reset command.
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps

module fpe_top #(
  parameter int unsigned TICK_CYCLES = fpe_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESET_N,
  // Measurements, 0.01 Hz, 0.1 Hz/s, 0.01 x CT, 0.01 x VT, signed 0.01 PF.
  input wire logic [15:0] FREQ,
  input wire logic [7:0] FREQ_FALL_RATE,
  input wire logic [15:0] IA,
  input wire logic [15:0] IB,
  input wire logic [15:0] IC,
  input wire logic [15:0] IN,
  input wire logic [15:0] VA,
  input wire logic [15:0] VB,
  input wire logic [15:0] VC,
  input wire logic [15:0] REAL_POWER,
  input wire logic [7:0] PFA,
  input wire logic [7:0] PFB,
  input wire logic [7:0] PFC,
  input wire logic TRIP_CMD,
  // Outputs to relay drivers and reclose logic.
  output logic TRIP,
  output logic ALARM,
  output logic CONTROL,
  output logic [4:0] AUX_RELAYS,
  output logic BF_DECLARED,
  output logic AR_LOCKOUT,
  // AXI4-Lite slave.
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [17:0] tick;
    logic [6:0] sec;
    fpe_pkg::fpe_func_e fd_func;
    logic [4:0] fd_rel;
    logic [15:0] fd_rate, fd_pu, fd_dly, fd_v, fd_i, fd_t;
    logic [4:0] bf_rel;
    logic [15:0] bf_i, bf_d1, bf_d2, bf1_t, bf2_t;
    logic rp_en;
    logic [4:0] rp_rel;
    logic [15:0] rp_pu, rp_dly, rp_t;
    fpe_pkg::fpe_func_e nc_func;
    logic [4:0] nc_rel;
    logic [15:0] nc_pu, nc_dly, nc_t;
    logic [1:0][4:0] pf_rel;
    logic [1:0][7:0] pf_pu, pf_dr;
    logic [1:0][15:0] pf_dly, pf_t;
    logic [1:0] pf_op;
    logic [7:0] pf_avg;
    logic fd_lat, nc_lat, lock;
    logic [5:0] st;
    logic trip, alarm, ctrl;
    logic [4:0] aux;
    logic bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } fpe_state_s;

  fpe_state_s q;
  fpe_state_s d;

  // Clamp a setting into its legal range.
  function automatic logic [15:0] lim(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    lim = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : lim

  // Delay timer: clears when idle, steps on the time base up to its delay.
  function automatic logic [15:0] tmr(input logic [15:0] t, input logic run, input logic step,
                                      input logic [15:0] dly);
    tmr = !run ? 16'h0 : ((step && t < dly) ? t + 16'h1 : t);
  endfunction : tmr

  // Unknown codes fall back to disabled so a bad write cannot arm an element.
  function automatic fpe_pkg::fpe_func_e fn(input logic [2:0] c, input logic no_trip);
    fn = (c > 3'h4 || (no_trip && c == 3'h1)) ? fpe_pkg::FN_OFF : fpe_pkg::fpe_func_e'(c);
  endfunction : fn

  // Read view of every register.
  function automatic logic [31:0] rw(input fpe_state_s s, input logic [7:0] a);
    case (a)
      fpe_pkg::A_FD_CFG: rw = {s.fd_dly, 2'h0, s.fd_rate[5:0], s.fd_rel, s.fd_func};
      fpe_pkg::A_FD_LVL: rw = {s.fd_i[7:0], s.fd_v[7:0], s.fd_pu};
      fpe_pkg::A_BF_CFG: rw = {s.bf_i, 11'h0, s.bf_rel};
      fpe_pkg::A_BF_DLY: rw = {s.bf_d2, s.bf_d1};
      fpe_pkg::A_RP_CFG: rw = {s.rp_pu, 10'h0, s.rp_en, s.rp_rel};
      fpe_pkg::A_RP_DLY: rw = {16'h0, s.rp_dly};
      fpe_pkg::A_NC_CFG: rw = {s.nc_dly, 8'h0, s.nc_rel, s.nc_func};
      fpe_pkg::A_NC_LVL: rw = {16'h0, s.nc_pu};
      fpe_pkg::A_PF_CFG0, fpe_pkg::A_PF_CFG1: rw = {8'h0, s.pf_dr[a[3]], s.pf_pu[a[3]], 3'h0, s.pf_rel[a[3]]};
      fpe_pkg::A_PF_DLY0, fpe_pkg::A_PF_DLY1: rw = {16'h0, s.pf_dly[a[3]]};
      fpe_pkg::A_STAT: rw = {18'h0, s.aux, s.nc_lat, s.fd_lat, s.lock, s.st};
      default: rw = 32'h0;
    endcase
  endfunction : rw

  // ---------------------------------------------------------------
  // Element conditions
  // ---------------------------------------------------------------
  logic wr, rd, clr, tick, sec, i_any, v30;
  logic fd_run, fd_op, bf_e1, bf_run2, bf_fail, rp_run, rp_op, nc_run, nc_op;
  logic [16:0] rp_mag;
  logic [9:0] pf_sum;
  logic [31:0] wmask, m;

  // Both write channels are taken together; no new request while an answer waits.
  assign wr = S_AXI_AWVALID && S_AXI_WVALID && !q.bvalid;
  assign rd = S_AXI_ARVALID && !q.rvalid;
  assign clr = wr && S_AXI_AWADDR == fpe_pkg::A_CMD && S_AXI_WSTRB[0] && S_AXI_WDATA[0];
  assign wmask = {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}}, {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
  assign m = (rw(q, S_AXI_AWADDR) & ~wmask) | (S_AXI_WDATA & wmask);
  assign tick = q.tick == 18'(TICK_CYCLES - 1);
  assign sec = tick && q.sec == 7'(fpe_pkg::SEC_TICKS - 1);
  assign i_any = |{IA, IB, IC};
  assign v30 = VA > fpe_pkg::V30 && VB > fpe_pkg::V30 && VC > fpe_pkg::V30;

  // Frequency decay with voltage and current supervision.
  assign fd_run = q.fd_func != fpe_pkg::FN_OFF // [RULE1]
    && (IA >= q.fd_i || IB >= q.fd_i || IC >= q.fd_i) // [RULE22]
    && (VA >= q.fd_v || VB >= q.fd_v || VC >= q.fd_v) // [RULE23]
    && FREQ < q.fd_pu && {8'h0, FREQ_FALL_RATE} > q.fd_rate; // [RULE24]
  assign fd_op = fd_run && q.fd_t >= q.fd_dly; // [RULE24]

  // Breaker failure with two cascaded timers.
  assign bf_e1 = TRIP_CMD && q.bf1_t >= q.bf_d1;
  assign bf_run2 = bf_e1 && (IA > q.bf_i || IB > q.bf_i || IC > q.bf_i); // [RULE11]
  assign bf_fail = bf_run2 && q.bf2_t >= q.bf_d2; // [RULE8]

  // Reverse power compares the magnitude of negative real power.
  assign rp_mag = ~{REAL_POWER[15], REAL_POWER} + 17'h1;
  assign rp_run = q.rp_en && REAL_POWER[15] && rp_mag > {1'b0, q.rp_pu}; // [RULE12]
  assign rp_op = rp_run && q.rp_t >= q.rp_dly;

  // Neutral level; a trip code is never stored for it.
  assign nc_run = q.nc_func != fpe_pkg::FN_OFF && IN >= q.nc_pu;
  assign nc_op = nc_run && q.nc_t >= q.nc_dly;
  assign pf_sum = {{2{PFA[7]}}, PFA} + {{2{PFB[7]}}, PFB} + {{2{PFC[7]}}, PFC};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    // Shared time base; long delays trade resolution for small counters.
    d.tick = tick ? 18'h0 : q.tick + 18'h1;
    d.sec = sec ? 7'h0 : (tick ? q.sec + 7'h1 : q.sec);
    d.fd_t = tmr(q.fd_t, fd_run, tick, q.fd_dly); // [RULE5]
    d.bf1_t = tmr(q.bf1_t, TRIP_CMD, tick, q.bf_d1); // [RULE10]
    d.bf2_t = tmr(q.bf2_t, bf_run2, tick, q.bf_d2); // [RULE11]
    d.rp_t = tmr(q.rp_t, rp_run, tick, q.rp_dly); // [RULE12]
    d.nc_t = tmr(q.nc_t, nc_run, sec, q.nc_dly); // [RULE15]
    d.pf_avg = 8'($signed(pf_sum) / 10'sd3); // [RULE16]
    // Two power factor stages with pickup and dropout hysteresis.
    for (int n = 0; n < 2; n++) begin
      d.pf_t[n] = tmr(q.pf_t[n], v30 && (q.pf_op[n] ? $signed(q.pf_avg) > $signed(q.pf_dr[n]) // [RULE20]
                  : ($signed(q.pf_avg) < $signed(q.pf_pu[n]) && i_any)), tick, q.pf_dly[n]); // [RULE19]
      if (!v30) begin
        d.pf_op[n] = 1'b0; // [RULE21]
      end else if (d.pf_t[n] == q.pf_t[n] && q.pf_t[n] >= q.pf_dly[n] && (q.pf_op[n] ?
                   $signed(q.pf_avg) > $signed(q.pf_dr[n]) : ($signed(q.pf_avg) < $signed(q.pf_pu[n]) && i_any))) begin
        d.pf_op[n] = !q.pf_op[n]; // [RULE17] [RULE18]
        d.pf_t[n] = 16'h0;
      end
    end
    // A new event wins over a clear arriving in the same cycle.
    d.fd_lat = (fd_op && q.fd_func == fpe_pkg::FN_LATCH) || (q.fd_lat && !clr); // [RULE25]
    d.nc_lat = (nc_op && q.nc_func == fpe_pkg::FN_LATCH) || (q.nc_lat && !clr); // [RULE25]
    d.lock = bf_fail || (q.lock && !clr); // [RULE9]
    d.st = {d.pf_op, nc_op, rp_op, bf_fail, fd_op};
    d.trip = fd_op && q.fd_func == fpe_pkg::FN_TRIP; // [RULE1]
    d.alarm = (fd_op && q.fd_func == fpe_pkg::FN_ALARM) || d.fd_lat || (nc_op && q.nc_func == fpe_pkg::FN_ALARM)
              || d.nc_lat;
    d.ctrl = (fd_op && q.fd_func == fpe_pkg::FN_CTRL) || (nc_op && q.nc_func == fpe_pkg::FN_CTRL);
    d.aux = ({5{fd_op || d.fd_lat}} & q.fd_rel) | ({5{bf_fail}} & q.bf_rel) | ({5{rp_op}} & q.rp_rel) // [RULE2]
            | ({5{nc_op || d.nc_lat}} & q.nc_rel) | ({5{d.pf_op[0]}} & q.pf_rel[0])
            | ({5{d.pf_op[1]}} & q.pf_rel[1]);
    // Register writes; decay and neutral settings are clamped into their legal ranges.
    if (wr) begin
      d.bvalid = 1'b1;
      d.bresp = (S_AXI_AWADDR[1:0] == 2'h0 && S_AXI_AWADDR <= fpe_pkg::A_STAT) ? fpe_pkg::RESP_OKAY
                : fpe_pkg::RESP_SLVERR;
      case (S_AXI_AWADDR)
        fpe_pkg::A_FD_CFG: begin
          d.fd_func = fn(m[2:0], 1'b0); // [RULE1]
          d.fd_rel = m[7:3];
          d.fd_rate = lim({10'h0, m[13:8]}, fpe_pkg::FD_RATE_MIN, fpe_pkg::FD_RATE_MAX); // [RULE3]
          d.fd_dly = lim(m[31:16], 16'h0, fpe_pkg::FD_DLY_MAX); // [RULE5]
        end
        fpe_pkg::A_FD_LVL: begin
          d.fd_pu = lim(m[15:0], fpe_pkg::FD_PU_MIN, fpe_pkg::FD_PU_MAX); // [RULE4]
          d.fd_v = lim({8'h0, m[23:16]}, 16'h0, fpe_pkg::SUP_MAX); // [RULE6]
          d.fd_i = lim({8'h0, m[31:24]}, 16'h0, fpe_pkg::SUP_MAX); // [RULE7]
        end
        fpe_pkg::A_BF_CFG: begin
          d.bf_rel = m[4:0];
          d.bf_i = m[31:16];
        end
        fpe_pkg::A_BF_DLY: begin
          d.bf_d1 = m[15:0];
          d.bf_d2 = m[31:16];
        end
        fpe_pkg::A_RP_CFG: begin
          d.rp_rel = m[4:0];
          d.rp_en = m[5];
          d.rp_pu = m[31:16];
        end
        fpe_pkg::A_RP_DLY: d.rp_dly = m[15:0];
        fpe_pkg::A_NC_CFG: begin
          d.nc_func = fn(m[2:0], 1'b1); // [RULE13]
          d.nc_rel = m[7:3];
          d.nc_dly = lim(m[31:16], 16'h0, fpe_pkg::NC_DLY_MAX); // [RULE15]
        end
        fpe_pkg::A_NC_LVL: d.nc_pu = lim(m[15:0], fpe_pkg::NC_PU_MIN, fpe_pkg::NC_PU_MAX); // [RULE14]
        fpe_pkg::A_PF_CFG0, fpe_pkg::A_PF_CFG1: begin
          d.pf_rel[S_AXI_AWADDR[3]] = m[4:0];
          d.pf_pu[S_AXI_AWADDR[3]] = m[15:8];
          d.pf_dr[S_AXI_AWADDR[3]] = m[23:16];
        end
        fpe_pkg::A_PF_DLY0, fpe_pkg::A_PF_DLY1: d.pf_dly[S_AXI_AWADDR[3]] = m[15:0];
        default: begin
        end
      endcase
    end else if (S_AXI_BREADY) begin
      d.bvalid = 1'b0;
    end
    // Register reads answer one cycle after the address is taken.
    if (rd) begin
      d.rvalid = 1'b1;
      d.rdata = rw(q, S_AXI_ARADDR);
      d.rresp = (S_AXI_ARADDR[1:0] == 2'h0 && S_AXI_ARADDR <= fpe_pkg::A_STAT) ? fpe_pkg::RESP_OKAY
                : fpe_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      d.rvalid = 1'b0;
    end
    // Synchronous reset loads the documented setting defaults.
    if (!RESET_N) begin
      d = '0;
      d.fd_func = fpe_pkg::FN_OFF;
      d.nc_func = fpe_pkg::FN_OFF;
      d.fd_rate = fpe_pkg::FD_RATE_RST;
      d.fd_pu = fpe_pkg::FD_PU_RST;
      d.fd_dly = fpe_pkg::FD_DLY_RST;
      d.fd_v = fpe_pkg::FD_V_RST;
      d.bf_i = fpe_pkg::BF_I_RST;
      d.bf_d1 = fpe_pkg::BF_DLY_RST;
      d.bf_d2 = fpe_pkg::BF_DLY_RST;
      d.rp_pu = fpe_pkg::RP_PU_RST;
      d.rp_dly = fpe_pkg::RP_DLY_RST;
      d.nc_pu = fpe_pkg::NC_PU_RST;
      d.nc_dly = fpe_pkg::NC_DLY_RST;
      d.pf_pu = {2{fpe_pkg::PF_PU_RST}};
      d.pf_dr = {2{fpe_pkg::PF_DR_RST}};
      d.pf_dly = {2{fpe_pkg::PF_DLY_RST}};
    end
  end

  // State register.
  always_ff @(posedge CLK) begin
    q <= d;
  end

  // Outputs straight from state; the ready signals come from the request decode.
  assign TRIP = q.trip;
  assign ALARM = q.alarm;
  assign CONTROL = q.ctrl;
  assign AUX_RELAYS = q.aux;
  assign BF_DECLARED = q.st[1];
  assign AR_LOCKOUT = q.lock;
  assign S_AXI_AWREADY = wr;
  assign S_AXI_WREADY = wr;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_ARREADY = rd;
  assign S_AXI_RVALID = q.rvalid;
  assign S_AXI_RDATA = q.rdata;
  assign S_AXI_RRESP = q.rresp;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  a_fd_inert_off: assert property (q.fd_func == fpe_pkg::FN_OFF |=> !q.st[0] && !q.trip) // [RULE1]
    else $error("Disabled decay element operated.");
  a_bf_relays: assert property (q.st[1] |-> (q.aux & $past(q.bf_rel)) == $past(q.bf_rel)) // [RULE2]
    else $error("Failure relays not driven.");
  a_fd_rate_rng: assert property (q.fd_rate >= 16'h0001 && q.fd_rate <= 16'h0032) // [RULE3]
    else $error("Decay rate out of range.");
  a_bf_cause: assert property (q.st[1] |-> $past(TRIP_CMD) && $past(bf_run2)) // [RULE8]
    else $error("Failure declared without trip and current.");
  a_bf_lockout: assert property (q.st[1] |-> q.lock ##1 q.lock) // [RULE9]
    else $error("Lockout not forced on failure.");
  a_bf1_idle: assert property (!TRIP_CMD |=> q.bf1_t == 16'h0) // [RULE10]
    else $error("First failure timer ran without trip.");
  a_bf2_gate: assert property (q.bf2_t != 16'h0 |-> $past(bf_run2)) // [RULE11]
    else $error("Second failure timer ran ungated.");
  a_rp_cause: assert property (q.st[2] |-> $past(rp_run)) // [RULE12]
    else $error("Reverse power operated without cause.");
  a_nc_no_trip: assert property (q.nc_func != fpe_pkg::FN_TRIP) // [RULE13]
    else $error("Neutral element holds a trip mode.");
  a_pf_vloss: assert property (!v30 |=> q.pf_op == 2'h0) // [RULE21]
    else $error("Power factor output kept on voltage loss.");
  a_fd_blocked: assert property (!fd_run |=> !q.st[0]) // [RULE22] [RULE23]
    else $error("Decay element operated while blocked.");
  a_latch_keep: assert property (q.fd_lat && !clr |=> q.fd_lat && q.alarm) // [RULE25]
    else $error("Latched alarm dropped without reset.");

  c_bf_fail: cover property (q.st[1]);
  c_pf_cycle: cover property (q.pf_op[0] ##1 !q.pf_op[0]);
  c_latch_held: cover property (q.fd_lat && !fd_run);
  c_slverr: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);

endmodule : fpe_top

/* File: verification/feeder_protection_elements_tb.sv */
// Self-checking bench for the feeder protection elements.
`timescale 1ns/1ps

module feeder_protection_elements_tb;
  localparam int unsigned TK = 4;
  logic clk = 1'b0, rst_n = 1'b0, trip_cmd = 1'b0;
  logic [15:0] f_s = 16'h1770, i_s = 16'h000a, v_s = 16'h0064, p_s = 16'h0000;
  logic [7:0] r_s = 8'h00, pf_s = 8'h64;
  logic [15:0] freq, ia, ib, va, pw;
  logic [7:0] rate, pfa, pfb, pfc, araddr = 8'h00, awaddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, trip, alarm, ctrl, bf, lock;
  logic [1:0] bresp, rresp;
  logic [4:0] aux, k;
  int errors = 0;
  int comparisons = 0;

  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // Front end model and design
  // ----------------------------------------------------------------
  fpe_front_end u_fe (.clk(clk), .f_s(f_s), .r_s(r_s), .i_s(i_s), .v_s(v_s), .p_s(p_s), .pf_s(pf_s),
    .freq(freq), .rate(rate), .ia(ia), .ib(ib), .va(va), .pw(pw), .pfa(pfa), .pfb(pfb), .pfc(pfc));
  // Phase C stays at zero, neutral follows phase B so the neutral element can pick up.
  fpe_top #(.TICK_CYCLES(TK)) u_dut (.CLK(clk), .RESET_N(rst_n), .FREQ(freq), .FREQ_FALL_RATE(rate),
    .IA(ia), .IB(ib), .IC(16'h0000), .IN(ib), .VA(va), .VB(va), .VC(va), .REAL_POWER(pw),
    .PFA(pfa), .PFB(pfb), .PFC(pfc), .TRIP_CMD(trip_cmd), .TRIP(trip), .ALARM(alarm), .CONTROL(ctrl),
    .AUX_RELAYS(aux), .BF_DECLARED(bf), .AR_LOCKOUT(lock), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Write and read hold each request until its ready, then wait for the answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while ((awready & wready) !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, fpe_pkg::RESP_OKAY});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd

  // Expected {trip, alarm, control, relays} of an operated decay element.
  function automatic logic [7:0] dec_exp(input int m, input logic [4:0] r);
    dec_exp = {m == 1, m == 2 || m == 3, m == 4, (m != 0) ? r : 5'h00};
  endfunction : dec_exp

  task automatic end_of_test();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(84574));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(fpe_pkg::A_FD_CFG, 32'h00c8_0a00, fpe_pkg::RESP_OKAY);
    rd(fpe_pkg::A_FD_LVL, 32'h0046_170c, fpe_pkg::RESP_OKAY);
    rd(fpe_pkg::A_NC_CFG, 32'h0002_0000, fpe_pkg::RESP_OKAY);
    rd(8'h38, 32'h0, fpe_pkg::RESP_SLVERR);
    // Out-of-range settings saturate at the ends of their ranges.
    wr(fpe_pkg::A_FD_CFG, 32'hffff_3f00);
    rd(fpe_pkg::A_FD_CFG, 32'hea60_3200, fpe_pkg::RESP_OKAY);
    wr(fpe_pkg::A_FD_LVL, 32'hffff_0000);
    rd(fpe_pkg::A_FD_LVL, 32'h7d7d_07d0, fpe_pkg::RESP_OKAY);
    wr(fpe_pkg::A_FD_LVL, 32'h0046_170c);
    wr(fpe_pkg::A_NC_LVL, 32'h0);
    rd(fpe_pkg::A_NC_LVL, 32'h0005, fpe_pkg::RESP_OKAY);
    wr(fpe_pkg::A_NC_CFG, 32'hffff_0001);
    rd(fpe_pkg::A_NC_CFG, 32'hea60_0000, fpe_pkg::RESP_OKAY);
    // Every decay function with a random relay mask and zero delay.
    for (int m = 0; m < 5; m++) begin
      k = 5'($urandom());
      wr(fpe_pkg::A_FD_CFG, {16'h0, 2'b00, 6'd10, k, 3'(m)});
      f_s <= 16'h16a8;
      r_s <= 8'd20;
      cyc(4);
      chk({trip, alarm, ctrl, aux}, dec_exp(m, k));
      f_s <= 16'h1770;
      cyc(4);
      chk({trip, alarm, ctrl}, {1'b0, m == 3, 1'b0});
      wr(fpe_pkg::A_CMD, 32'h1);
      cyc(2);
      chk(alarm, 1'b0);
    end
    wr(fpe_pkg::A_FD_CFG, {16'h0, 2'b00, 6'd10, 5'h00, 3'h1});
    v_s <= 16'h0045;
    f_s <= 16'h16a8;
    cyc(4);
    chk(trip, 1'b0);
    wr(fpe_pkg::A_FD_LVL, 32'h1446_170c);
    v_s <= 16'h0064;
    cyc(4);
    chk(trip, 1'b0);
    i_s <= 16'h0014;
    cyc(4);
    chk(trip, 1'b1);
    f_s <= 16'h1770;
    wr(fpe_pkg::A_FD_CFG, {16'd3, 2'b00, 6'd10, 5'h00, 3'h1});
    f_s <= 16'h16a8;
    cyc(4);
    chk(trip, 1'b0);
    cyc(14);
    chk(trip, 1'b1);
    f_s <= 16'h1770;
    wr(fpe_pkg::A_FD_CFG, 32'h0);
    // Reverse power at exactly the pickup, then one step beyond it.
    wr(fpe_pkg::A_RP_DLY, 32'h1);
    wr(fpe_pkg::A_RP_CFG, {16'd16, 10'h0, 1'b1, 5'h10});
    p_s <= 16'hfff0;
    cyc(12);
    chk(aux, 5'h00);
    p_s <= 16'hffef;
    cyc(12);
    chk(aux, 5'h10);
    p_s <= 16'h0000;
    // Breaker failure: current below the level first, then above it with the trip held.
    wr(fpe_pkg::A_BF_DLY, {16'd2, 16'd2});
    wr(fpe_pkg::A_BF_CFG, {16'd100, 11'h0, 5'h09});
    i_s <= 16'd50;
    trip_cmd <= 1'b1;
    cyc(25);
    chk(bf, 1'b0);
    i_s <= 16'd200;
    cyc(3);
    chk(bf, 1'b0);
    cyc(12);
    chk({bf, lock, aux}, {2'b11, 5'h09});
    trip_cmd <= 1'b0;
    i_s <= 16'h000a;
    cyc(3);
    chk({bf, lock}, 2'b01);
    wr(fpe_pkg::A_CMD, 32'h1);
    cyc(2);
    chk(lock, 1'b0);
    // Power factor stage one: inhibit, operate, hold in the band, reset, voltage loss.
    wr(fpe_pkg::A_PF_DLY0, 32'h2);
    wr(fpe_pkg::A_PF_CFG0, 32'h005a_5002);
    v_s <= 16'h001e;
    pf_s <= 8'h46;
    cyc(14);
    chk(aux, 5'h00);
    v_s <= 16'h0064;
    cyc(14);
    rd(fpe_pkg::A_STAT, 32'h0000_0410, fpe_pkg::RESP_OKAY);
    pf_s <= 8'h50;
    cyc(14);
    chk(aux, 5'h02);
    pf_s <= 8'h64;
    cyc(4);
    chk(aux, 5'h02);
    cyc(14);
    chk(aux, 5'h00);
    pf_s <= 8'h46;
    cyc(14);
    chk(aux, 5'h02);
    v_s <= 16'h0014;
    cyc(4);
    chk(aux, 5'h00);
    // Neutral level in control with a two second delay; the second boundary has a free phase.
    wr(fpe_pkg::A_NC_CFG, {16'd2, 8'h00, 5'h04, 3'h4});
    cyc(300);
    chk({ctrl, aux}, {1'b0, 5'h00});
    cyc(520);
    chk({ctrl, aux}, {1'b1, 5'h04});
    end_of_test();
  end

  // Watchdog well beyond the roughly 1200 cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule : feeder_protection_elements_tb

/* File: verification/fpe_front_end.sv */
// Measurement front end model that turns requested quantities into per-phase inputs.
`timescale 1ns/1ps

module fpe_front_end (
  // Clock.
  input wire logic clk,
  // Requested quantities.
  input wire logic [15:0] f_s,
  input wire logic [7:0] r_s,
  input wire logic [15:0] i_s,
  input wire logic [15:0] v_s,
  input wire logic [15:0] p_s,
  input wire logic [7:0] pf_s,
  // Per-phase measurements.
  output logic [15:0] freq,
  output logic [7:0] rate,
  output logic [15:0] ia,
  output logic [15:0] ib,
  output logic [15:0] va,
  output logic [15:0] pw,
  output logic [7:0] pfa,
  output logic [7:0] pfb,
  output logic [7:0] pfc
);
  // ----------------------------------------------------------------
  // Sampling with one cycle of latency
  // ----------------------------------------------------------------
  // Power factor phases A and B are skewed in opposite directions so that their average, like phase C, equals the request.
  always @(posedge clk) begin
    freq <= f_s;
    rate <= r_s;
    ia <= i_s;
    ib <= i_s >> 1;
    va <= v_s;
    pw <= p_s;
    pfa <= pf_s + 8'h06;
    pfb <= pf_s - 8'h06;
    pfc <= pf_s;
  end
endmodule : fpe_front_end
